// ---- epvr_resolver.sv ----
module epvr_resolver
  import epvr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [epvr_pkg::NUM_IRQ-1:0] irq_req,
  input wire logic nmi_req,
  input wire logic hardfault_req,
  input wire logic [epvr_pkg::NUM_EXC-1:0] sys_req,
  input wire logic [epvr_pkg::NUM_EXC*epvr_pkg::PRI_W-1:0] pri_wdata,
  input wire logic pri_we,
  input wire logic [2:0] split_wdata,
  input wire logic split_we,
  input wire logic [31:0] vtab_wdata,
  input wire logic vtab_we,
  input wire logic running_valid,
  input wire logic signed [4:0] running_group,
  output logic take_valid,
  output logic [epvr_pkg::VEC_W-1:0] take_vector,
  output logic [31:0] take_addr,
  output logic take_preempt,
  output logic signed [4:0] take_group,
  output logic [31:0] sp_fetch_addr,
  output logic [31:0] reset_fetch_addr,
  output logic [31:0] vector_base_offset_reg
);
  import epvr_pkg::*;

  logic [NUM_EXC*PRI_W-1:0] pri_reg, pri_next;
  logic [2:0] split_reg, split_next;
  logic [31:0] vtab_next;
  logic [NUM_EXC-1:0] pend;
  logic best_v;
  logic [VEC_W-1:0] best_n;
  logic signed [4:0] best_g;
  logic [PRI_W-1:0] best_s;
  logic signed [4:0] cg;
  logic [PRI_W-1:0] cs;
  logic [PRI_W-1:0] gmask;
  logic better;
  logic v_next;
  logic [VEC_W-1:0] n_next;
  logic [31:0] a_next;
  logic p_next;
  logic signed [4:0] g_next;

  always_comb
  begin
    pri_next = pri_reg;
    split_next = split_reg;
    vtab_next = vector_base_offset_reg;
    if (pri_we)
    begin
      pri_next = pri_wdata;
    end
    if (split_we)
    begin
      split_next = split_wdata;
    end
    if (vtab_we && ((vtab_wdata & VTAB_ALIGN_MASK) >= VTAB_MIN)
        && ((vtab_wdata & VTAB_ALIGN_MASK) <= VTAB_MAX))
    begin
      vtab_next = vtab_wdata & VTAB_ALIGN_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pri_reg <= {NUM_EXC{PRI_RESET}};
      split_reg <= SPLIT_RESET;
      vector_base_offset_reg <= VTAB_RESET;
    end
    else
    begin
      pri_reg <= pri_next;
      split_reg <= split_next;
      vector_base_offset_reg <= vtab_next;
    end
  end

  // stack pointer at slot 0, reset handler at slot 1
  assign sp_fetch_addr = vector_base_offset_reg;
  assign reset_fetch_addr = vector_base_offset_reg + 32'h0000_0004;

  always_comb
  begin
    pend = sys_req & EXC_VALID_MASK;
    pend[IRQ_VEC_OFS +: NUM_IRQ] = irq_req & EXC_VALID_MASK[IRQ_VEC_OFS +: NUM_IRQ];
    pend[VEC_NMI] = nmi_req;
    pend[VEC_HARDFAULT] = hardfault_req;
    pend[VEC_RESET] = 1'b0;
    pend[0] = 1'b0;
  end

  // group mask: split=k leaves top (PRI_W-k) bits as group
  always_comb
  begin
    gmask = 3'h7;
    if (split_reg >= 3'h3)
    begin
      gmask = 3'h0;
    end
    else
    begin
      gmask = 3'(3'h7 << split_reg);
    end
  end

  always_comb
  begin
    best_v = 1'b0;
    best_n = '0;
    best_g = LVL_IDLE;
    best_s = '0;
    cg = LVL_IDLE;
    cs = '0;
    better = 1'b0;
    for (int i = NUM_EXC - 1; i >= 0; i--)
    begin
      if (i == int'(VEC_NMI))
      begin
        cg = LVL_NMI;
        cs = '0;
      end
      else if (i == int'(VEC_HARDFAULT))
      begin
        cg = LVL_HARDFAULT;
        cs = '0;
      end
      else
      begin
        cg = $signed({2'b00, pri_reg[i*PRI_W +: PRI_W] & gmask});
        cs = pri_reg[i*PRI_W +: PRI_W] & ~gmask;
      end
      // descending scan with <= keeps the lowest number on ties
      better = !best_v || (cg < best_g) || ((cg == best_g) && (cs <= best_s));
      if (pend[i] && better)
      begin
        best_v = 1'b1;
        best_n = VEC_W'(i);
        best_g = cg;
        best_s = cs;
      end
    end
  end

  always_comb
  begin
    // only strictly more urgent group is taken while a handler runs
    v_next = best_v && (!running_valid || (best_g < running_group));
    n_next = best_n;
    a_next = vector_base_offset_reg + {24'h0, best_n, 2'b00};
    p_next = v_next && running_valid;
    g_next = best_g;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      take_valid <= 1'b0;
      take_vector <= VEC_RESET;
      take_addr <= TAKE_ADDR_RESET;
      take_preempt <= 1'b0;
      take_group <= LVL_RESET;
    end
    else
    begin
      take_valid <= v_next;
      take_vector <= n_next;
      take_addr <= a_next;
      take_preempt <= p_next;
      take_group <= g_next;
    end
  end

  property p_addr_map;
    @(posedge ref_clk) disable iff (rst)
    take_valid |-> take_addr == $past(vector_base_offset_reg) + {24'h0, take_vector, 2'b00};
  endproperty
  a_addr_map: assert property (p_addr_map) else $error("vector address mismatch");

  property p_no_equal_preempt;
    @(posedge ref_clk) disable iff (rst)
    $past(running_valid) && take_valid |-> take_group < $past(running_group);
  endproperty
  a_no_equal_preempt: assert property (p_no_equal_preempt) else $error("equal preempt");

  property p_nmi_wins;
    @(posedge ref_clk) disable iff (rst)
    nmi_req && !running_valid |=> take_valid && take_vector == VEC_NMI && take_group == -5'sd2;
  endproperty
  a_nmi_wins: assert property (p_nmi_wins) else $error("nmi not selected");

  property p_hf_over_prog;
    @(posedge ref_clk) disable iff (rst)
    hardfault_req && !nmi_req && !running_valid |=> take_vector == VEC_HARDFAULT;
  endproperty
  a_hf_over_prog: assert property (p_hf_over_prog) else $error("hard fault lost");

  property p_reserved;
    @(posedge ref_clk) disable iff (rst)
    take_valid |-> EXC_VALID_MASK[take_vector];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved vector taken");

  property p_vtab_range;
    @(posedge ref_clk) disable iff (rst)
    vector_base_offset_reg == 32'h0 ||
      (vector_base_offset_reg >= VTAB_MIN && vector_base_offset_reg <= VTAB_MAX);
  endproperty
  a_vtab_range: assert property (p_vtab_range) else $error("table base out of range");

  property p_take_when_idle;
    @(posedge ref_clk) disable iff (rst)
    (|(irq_req & EXC_VALID_MASK[IRQ_VEC_OFS +: NUM_IRQ])) && !running_valid ##1 !running_valid
      |-> take_valid;
  endproperty
  a_take_when_idle: assert property (p_take_when_idle) else $error("pending not taken");

  property p_preempt_flag;
    @(posedge ref_clk) disable iff (rst)
    take_preempt |-> take_valid && $past(running_valid);
  endproperty
  a_preempt_flag: assert property (p_preempt_flag) else $error("bad preempt flag");

  property p_reset_fetch;
    @(posedge ref_clk) disable iff (rst)
    reset_fetch_addr == sp_fetch_addr + 32'h4;
  endproperty
  a_reset_fetch: assert property (p_reset_fetch) else $error("reset fetch address");
endmodule // epvr_resolver

// ---- epvr_pkg.sv ----
package epvr_pkg;
  localparam int NUM_IRQ = 48;
  localparam int NUM_EXC = 64;
  localparam int PRI_W = 3;
  localparam int VEC_W = 6;
  localparam int IRQ_VEC_OFS = 16;
  localparam logic [31:0] VTAB_RESET = 32'h0000_0000;
  localparam logic [31:0] VTAB_MIN = 32'h0000_0100;
  localparam logic [31:0] VTAB_MAX = 32'h3fff_ff00;
  localparam logic [31:0] VTAB_ALIGN_MASK = 32'hffff_ff00;
  localparam logic [PRI_W-1:0] PRI_RESET = 3'h0;
  localparam logic [2:0] SPLIT_RESET = 3'h0;
  localparam logic [VEC_W-1:0] VEC_RESET = 6'h01;
  localparam logic [VEC_W-1:0] VEC_NMI = 6'h02;
  localparam logic [VEC_W-1:0] VEC_HARDFAULT = 6'h03;
  localparam logic [31:0] TAKE_ADDR_RESET = 32'h0000_0004;
  // signed 5-bit urgency: fixed levels sit below all programmable ones
  localparam logic signed [4:0] LVL_RESET = -5'sd3;
  localparam logic signed [4:0] LVL_NMI = -5'sd2;
  localparam logic signed [4:0] LVL_HARDFAULT = -5'sd1;
  localparam logic signed [4:0] LVL_IDLE = 5'sd15;
  // reserved exception vectors 7-10,13 and reserved irq numbers
  localparam logic [NUM_EXC-1:0] EXC_VALID_MASK =
    64'hc83a_31ff_c1ff_d87e;
endpackage

// ---- epvr_core_model.sv ----
module epvr_core_model
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic accept,
  input wire logic leave,
  input wire logic take_valid,
  input wire logic signed [4:0] take_group,
  output logic running_valid,
  output logic signed [4:0] running_group
);
  timeunit 1ns;
  timeprecision 1ps;
  // latches the taken level; stale level is scrambled once released
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      running_valid <= 1'b0;
      running_group <= 5'sh0f;
    end
    else if (accept && take_valid)
    begin
      running_valid <= 1'b1;
      running_group <= take_group;
    end
    else if (leave)
    begin
      running_valid <= 1'b0;
      running_group <= ~running_group;
    end
  end
endmodule // epvr_core_model

// ---- exception_priority_vector_resolver_tb.sv ----
module exception_priority_vector_resolver_tb;
  import epvr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst = 1'b1, nmi_req = 1'b0, hardfault_req = 1'b0;
  logic pri_we = 1'b0, split_we = 1'b0, vtab_we = 1'b0, accept = 1'b0, leave = 1'b0;
  logic [NUM_IRQ-1:0] irq_req = '0;
  logic [NUM_EXC-1:0] sys_req = '0;
  logic [NUM_EXC*PRI_W-1:0] pri_wdata = '0;
  logic [2:0] split_wdata = 3'h0;
  logic [31:0] vtab_wdata = 32'h0, base = 32'h0;
  logic running_valid, take_valid, take_preempt;
  logic signed [4:0] running_group, take_group;
  logic [VEC_W-1:0] take_vector;
  logic [31:0] take_addr, sp_fetch_addr, reset_fetch_addr, vector_base_offset_reg;
  logic [39:0] exp_q[$], e;
  int bad_count = 0, num_checks = 0, a, b;
  epvr_resolver u_epvr_resolver (.ref_clk, .rst, .irq_req, .nmi_req, .hardfault_req,
    .sys_req, .pri_wdata, .pri_we, .split_wdata, .split_we, .vtab_wdata, .vtab_we,
    .running_valid, .running_group, .take_valid, .take_vector, .take_addr,
    .take_preempt, .take_group, .sp_fetch_addr, .reset_fetch_addr,
    .vector_base_offset_reg);
  epvr_core_model u_epvr_core_model (.ref_clk, .rst, .accept, .leave, .take_valid,
    .take_group, .running_valid, .running_group);
  initial
    forever #2.5 ref_clk = ~ref_clk;
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(logic [38:0] got, logic [38:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic want(logic v, logic [5:0] vec);
    @(posedge ref_clk);
    // preemption expected when the partner was running at this edge
    exp_q.push_back(v ? {running_valid, 1'b1, vec, base + {24'h0, vec, 2'b00}} : 40'h0);
    @(negedge ref_clk);
  endtask
  task automatic cfg(logic [2:0] k);
    pri_we = 1'b1;
    split_wdata = k;
    split_we = 1'b1;
    @(negedge ref_clk);
    pri_we = 1'b0;
    split_we = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic hold(logic go, logic stop);
    accept = go;
    leave = stop;
    @(negedge ref_clk);
    accept = 1'b0;
    leave = 1'b0;
  endtask
  task automatic vt(logic [31:0] d, logic ok);
    vtab_wdata = d;
    vtab_we = 1'b1;
    @(negedge ref_clk);
    vtab_we = 1'b0;
    if (ok)
      base = d;
    @(negedge ref_clk);
    chk({7'h0, vector_base_offset_reg}, {7'h0, base});
    chk({7'h0, reset_fetch_addr}, {7'h0, base + 32'h4});
  endtask
  function automatic int pick();
    int n;
    do n = $urandom % NUM_IRQ;
    while (!EXC_VALID_MASK[n + IRQ_VEC_OFS]);
    return n;
  endfunction
  always @(negedge ref_clk)
    if (exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      chk(e[38] ? {take_valid, take_vector, take_addr} : {take_valid, 38'h0}, e[38:0]);
      chk({38'h0, take_preempt}, {38'h0, e[39]});
      chk({37'h0, take_addr[1:0]}, 39'h0);
    end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    results();
  end
  initial
  begin
    void'($urandom(86109));
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    chk({7'h0, sp_fetch_addr}, 39'h0);
    chk({7'h0, reset_fetch_addr}, 39'h4);
    a = pick();
    b = pick();
    irq_req[a] = 1'b1;
    want(1'b1, 6'(a + 16));
    irq_req[b] = 1'b1;
    want(1'b1, 6'(((a < b) ? a : b) + 16));
    sys_req[15] = 1'b1;
    want(1'b1, 6'h0f);
    irq_req = '0;
    sys_req = '0;
    irq_req[9] = 1'b1;
    sys_req[7] = 1'b1;
    want(1'b0, 6'h0);
    irq_req = '0;
    sys_req = '0;
    $display("test selection done");
    pri_wdata[3*16 +: 3] = 3'h5;
    pri_wdata[3*17 +: 3] = 3'h2;
    cfg(3'h0);
    irq_req[1:0] = 2'b11;
    want(1'b1, 6'h11);
    irq_req = '0;
    pri_wdata[3*16 +: 3] = 3'h3;
    pri_wdata[3*17 +: 3] = 3'h2;
    cfg(3'h1);
    irq_req[1:0] = 2'b11;
    want(1'b1, 6'h11);
    hold(1'b1, 1'b0);
    irq_req[0] = 1'b1;
    want(1'b0, 6'h0);
    pri_wdata[3*16 +: 3] = 3'h0;
    cfg(3'h1);
    want(1'b1, 6'h10);
    irq_req = '0;
    pri_wdata[3*17 +: 3] = 3'h0;
    hold(1'b0, 1'b1);
    cfg(3'h0);
    irq_req[1] = 1'b1;
    want(1'b1, 6'h11);
    hold(1'b1, 1'b0);
    irq_req[0] = 1'b1;
    want(1'b0, 6'h0);
    hold(1'b0, 1'b1);
    $display("test preemption done");
    nmi_req = 1'b1;
    want(1'b1, 6'h02);
    hold(1'b1, 1'b0);
    hardfault_req = 1'b1;
    want(1'b0, 6'h0);
    nmi_req = 1'b0;
    want(1'b0, 6'h0);
    hold(1'b0, 1'b1);
    want(1'b1, 6'h03);
    hardfault_req = 1'b0;
    irq_req = '0;
    $display("test fixed levels done");
    vt(32'h2000_0300, 1'b1);
    vt(32'h0000_0080, 1'b0);
    vt(32'h3fff_ff00, 1'b1);
    irq_req[a] = 1'b1;
    want(1'b1, 6'(a + 16));
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    base = 32'h0;
    chk({7'h0, vector_base_offset_reg}, 39'h0);
    want(1'b1, 6'(a + 16));
    @(negedge ref_clk);
    $display("test relocation done");
    results();
  end
endmodule // exception_priority_vector_resolver_tb
